// File: shared/sadc_pkg.sv
// Package with register map, field positions, reset values and timing
// constants for the successive-approximation converter sequencer.
// Assumes a 50 MHz APB clock and an external analog comparator.
package sadc_pkg;

	// --------------------------------------------------------------
	// Register indices and byte addresses
	// --------------------------------------------------------------
	localparam logic [7:0] sadc_result_idx = 8'h0a;
	localparam logic [7:0] sadc_ctrl_idx = 8'h0b;
	localparam logic [7:0] sadc_irq_status_idx = 8'h0c;
	localparam logic [7:0] sadc_irq_mask_idx = 8'h0d;
	localparam logic [11:0] sadc_result_addr = {2'h0, sadc_result_idx, 2'h0};
	localparam logic [11:0] sadc_ctrl_addr = {2'h0, sadc_ctrl_idx, 2'h0};
	localparam logic [11:0] sadc_irq_status_addr =
		{2'h0, sadc_irq_status_idx, 2'h0};
	localparam logic [11:0] sadc_irq_mask_addr =
		{2'h0, sadc_irq_mask_idx, 2'h0};

	// --------------------------------------------------------------
	// Field positions and reset values
	// --------------------------------------------------------------
	localparam int sadc_done_bit = 7;
	localparam int sadc_on_bit = 5;
	localparam logic [7:0] sadc_ctrl_reset = 8'h00;
	localparam logic [7:0] sadc_result_reset = 8'h00;
	localparam logic [7:0] sadc_full_scale = 8'hff;
	localparam logic [7:0] sadc_zero_scale = 8'h00;

	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int sadc_clk_div = 4;
	localparam int sadc_conv_periods = 12;
	localparam int sadc_steps = 8;
	localparam int sadc_load_periods = sadc_conv_periods - sadc_steps;
	localparam logic [1:0] sadc_div_last = 2'(sadc_clk_div - 1);
	localparam logic [3:0] sadc_load_last = 4'(sadc_load_periods - 1);
	localparam logic [3:0] sadc_step_last = 4'(sadc_steps - 1);
	localparam int sadc_conv_cycles = sadc_conv_periods * sadc_clk_div;

	typedef enum logic [1:0] {
		sadc_off,
		sadc_load,
		sadc_approx
	} sadc_phase_t;

endpackage : sadc_pkg

// File: hdl/sadc_sequencer.sv
// Sequencer for an 8-bit successive-approximation converter with APB
// register access. Assumes an external sample-and-hold and comparator
// that answer within one converter clock period.

// Summary of operation
// - An input at or above the upper reference yields code ff with no overflow flag.
// - An input at or below the lower reference yields code 00.
// - Each conversion is a sample phase then 8 approximation steps with the capacitor isolated.
// - While on, sample and conversion phases repeat back to back on their own.
// - A conversion lasts 12 converter clocks, each four CPU clocks long.
// - Setting the on bit (bit 5) starts converting until the bit is cleared.
// - Each finished conversion sets the done flag (bit 7) and interrupt status bit 0, which drives irq when bit 0 of the mask is set.
// - A result stays stable until the next conversion finishes.
// - A control write with the on bit set aborts, clears the done flag and restarts sampling.
// - Reading the result or writing control clears the done flag.
// - With the on bit clear no conversion runs.
// - Channel select bits 3:0 give the input index 0 to 15 in binary.
// - Reset clears all four registers and the result is read-only.
// - CPU wait mode has no effect on the converter.
module sadc_sequencer
	import sadc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cpu_wait,
	input wire logic comp_above,
	input wire logic at_upper_ref,
	input wire logic at_lower_ref,
	output logic [3:0] channel_select,
	output logic sample_connect,
	output logic [7:0] dac_code,
	output logic converter_on,
	output logic irq
);

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] result;
		logic [7:0] trial;
		logic [1:0] div;
		logic [3:0] count;
		sadc_phase_t phase;
		logic [1:0] irq_status;
		logic [1:0] irq_mask;
		logic [31:0] rdata;
	} sadc_state_t;

	sadc_state_t st;
	sadc_state_t next_st;

	function automatic logic [7:0] bit_mask(input logic [3:0] pos);
		bit_mask = 8'h80 >> pos;
	endfunction

	function automatic logic [5:0] elapsed(input sadc_phase_t ph,
		input logic [3:0] cnt, input logic [1:0] dv);
		elapsed = {cnt, dv};
		if (ph == sadc_approx) begin
			elapsed = 6'(elapsed + 6'(sadc_load_periods * sadc_clk_div));
		end
	endfunction

	logic acc;
	logic wr_ctrl;
	logic rd_result;
	logic tick;
	logic conv_end;
	logic [7:0] final_code;
	logic [7:0] kept;

	assign acc = psel && penable;
	assign wr_ctrl = acc && pwrite && paddr == sadc_ctrl_addr;
	assign rd_result = acc && !pwrite && paddr == sadc_result_addr;
	assign tick = st.div == sadc_div_last;
	assign conv_end = st.phase == sadc_approx && tick
		&& st.count == sadc_step_last;
	assign kept = comp_above ? st.trial
		: st.trial & ~bit_mask(st.count);

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb begin
		next_st = st;
		final_code = kept;
		if (at_upper_ref) begin
			final_code = sadc_full_scale;
		end else if (at_lower_ref) begin
			final_code = sadc_zero_scale;
		end
		next_st.div = 2'(st.div + 2'h1);
		// The converter ignores cpu_wait entirely.
		case (st.phase)
			sadc_off: begin
				next_st.div = 2'h0;
				next_st.count = 4'h0;
				if (st.ctrl[sadc_on_bit]) begin
					next_st.phase = sadc_load;
				end
			end
			sadc_load: begin
				if (tick) begin
					next_st.count = 4'(st.count + 4'h1);
					if (st.count == sadc_load_last) begin
						next_st.phase = sadc_approx;
						next_st.count = 4'h0;
						next_st.trial = bit_mask(4'h0);
					end
				end
			end
			sadc_approx: begin
				if (tick) begin
					next_st.count = 4'(st.count + 4'h1);
					next_st.trial = kept | bit_mask(4'(st.count + 4'h1));
					if (conv_end) begin
						next_st.result = final_code;
						next_st.ctrl[sadc_done_bit] = 1'b1;
						next_st.irq_status[0] = 1'b1;
						next_st.phase = sadc_load;
						next_st.count = 4'h0;
					end
				end
			end
			default: begin
				next_st.phase = sadc_off;
			end
		endcase
		if (!st.ctrl[sadc_on_bit]) begin
			next_st.phase = sadc_off;
		end
		// Register writes and read side effects.
		if (rd_result && !conv_end) begin
			next_st.ctrl[sadc_done_bit] = 1'b0;
		end
		if (acc && pwrite) begin
			case (paddr)
				sadc_ctrl_addr: begin
					next_st.ctrl = {1'b0, 1'b0, pwdata[5], 1'b0,
						pwdata[3:0]};
					if (pwdata[sadc_on_bit]) begin
						next_st.phase = sadc_load;
						next_st.div = 2'h0;
						next_st.count = 4'h0;
					end else begin
						next_st.phase = sadc_off;
					end
				end
				sadc_irq_status_addr: begin
					next_st.irq_status = (st.irq_status & ~pwdata[1:0])
						| {wr_ctrl, conv_end};
				end
				sadc_irq_mask_addr: begin
					next_st.irq_mask = pwdata[1:0];
				end
				default: begin
				end
			endcase
		end
		if (wr_ctrl) begin
			next_st.irq_status[1] = 1'b1;
		end
		next_st.rdata = 32'h0;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				sadc_result_addr: next_st.rdata = {24'h0, st.result};
				sadc_ctrl_addr: next_st.rdata = {24'h0, st.ctrl};
				sadc_irq_status_addr: next_st.rdata = {30'h0, st.irq_status};
				sadc_irq_mask_addr: next_st.rdata = {30'h0, st.irq_mask};
				default: next_st.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '{ctrl: sadc_ctrl_reset, result: sadc_result_reset,
				trial: 8'h00, div: 2'h0, count: 4'h0, phase: sadc_off,
				irq_status: 2'h0, irq_mask: 2'h0,
				rdata: 32'h0};
		end else begin
			st <= next_st;
		end
	end

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	assign prdata = st.rdata;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign channel_select = st.ctrl[3:0];
	assign sample_connect = st.phase == sadc_load;
	assign dac_code = st.trial;
	assign converter_on = st.ctrl[sadc_on_bit];
	assign irq = |(st.irq_status & st.irq_mask);

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	sequence s_ends;
		conv_end && !wr_ctrl;
	endsequence

	a_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
		s_ends |=> st.ctrl[sadc_done_bit])
		else $error("done flag not set at end");
	a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		s_ends and rd_result |=> st.ctrl[sadc_done_bit])
		else $error("read clear beat conversion end");
	a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
		rd_result && !conv_end |=> !st.ctrl[sadc_done_bit])
		else $error("result read left done flag");
	a_write_restart: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ctrl && pwdata[sadc_on_bit] |=> st.phase == sadc_load
		&& !st.ctrl[sadc_done_bit] && st.count == 4'h0)
		else $error("control write did not restart");
	a_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!converter_on && !wr_ctrl |=> st.phase == sadc_off)
		else $error("conversion while off");
	a_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!conv_end |=> st.result == $past(st.result))
		else $error("result changed mid conversion");
	a_full_scale: assert property (@(posedge pclk) disable iff (!presetn)
		conv_end && at_upper_ref |=> st.result == sadc_full_scale)
		else $error("full scale code missing");
	a_zero_scale: assert property (@(posedge pclk) disable iff (!presetn)
		conv_end && !at_upper_ref && at_lower_ref
		|=> st.result == sadc_zero_scale)
		else $error("zero code missing");
	a_period: assert property (@(posedge pclk) disable iff (!presetn)
		st.phase == sadc_off ##1 st.phase == sadc_load
		|-> ##47 conv_end or ##[1:46] wr_ctrl)
		else $error("conversion length not 48 cycles");
	a_isolated: assert property (@(posedge pclk) disable iff (!presetn)
		st.phase == sadc_approx |-> !sample_connect)
		else $error("capacitor connected while stepping");


	// --------------------------------------------------------------
	// Phase sequencing checks
	// --------------------------------------------------------------
	sequence s_starts;
		st.phase == sadc_off ##1 st.phase == sadc_load;
	endsequence
	sequence s_enters_steps;
		st.phase == sadc_load ##1 st.phase == sadc_approx;
	endsequence
	sequence s_leaves_steps;
		st.phase == sadc_approx ##1 st.phase == sadc_load;
	endsequence
	sequence s_loads_tick;
		st.phase == sadc_load && tick && !wr_ctrl;
	endsequence
	sequence s_steps_tick;
		st.phase == sadc_approx && tick && !wr_ctrl;
	endsequence

	a_start_fresh: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_starts |-> st.count == 4'h0 && st.div == 2'h0)
		else $error("conversion did not start fresh");

	a_load_to_steps: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_loads_tick and st.count == sadc_load_last
		|=> st.phase == sadc_approx)
		else $error("load phase did not end on time");

	a_trial_top: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_enters_steps |-> dac_code == bit_mask(4'h0))
		else $error("first trial code wrong");

	a_step_next: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_steps_tick and st.count != sadc_step_last
		|=> st.phase == sadc_approx)
		else $error("steps ended early");

	a_back_to_back: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_steps_tick and st.count == sadc_step_last
		|=> sample_connect && st.count == 4'h0 && st.div == 2'h0)
		else $error("next conversion did not follow");

	a_leave_at_end: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_leaves_steps |-> $past(conv_end) || $past(wr_ctrl))
		else $error("steps left without cause");

	a_end_at_47: assert property (
		@(posedge pclk) disable iff (!presetn)
		conv_end
		|-> elapsed(st.phase, st.count, st.div) == 6'(sadc_conv_cycles - 1))
		else $error("conversion end at wrong cycle");

	a_div_pace: assert property (
		@(posedge pclk) disable iff (!presetn)
		st.phase != sadc_off && !wr_ctrl
		|=> st.div == 2'($past(st.div) + 2'h1))
		else $error("converter clock divider skipped");

	a_count_load: assert property (
		@(posedge pclk) disable iff (!presetn)
		st.phase == sadc_load |-> st.count <= sadc_load_last)
		else $error("load count out of range");

	a_count_steps: assert property (
		@(posedge pclk) disable iff (!presetn)
		st.phase == sadc_approx |-> st.count <= sadc_step_last)
		else $error("step count out of range");

	a_sample_load: assert property (
		@(posedge pclk) disable iff (!presetn)
		sample_connect |-> st.phase == sadc_load)
		else $error("capacitor connected outside load");

	a_on_follows: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> converter_on == $past(pwdata[sadc_on_bit]))
		else $error("on bit not taken from write");

	a_channel_reg: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> channel_select == $past(pwdata[3:0]))
		else $error("channel not taken from write");

	a_done_only_end: assert property (
		@(posedge pclk) disable iff (!presetn)
		!conv_end |=> !$rose(st.ctrl[sadc_done_bit]))
		else $error("done flag set without conversion end");

	a_done_sticky: assert property (
		@(posedge pclk) disable iff (!presetn)
		st.ctrl[sadc_done_bit] && !rd_result && !wr_ctrl
		|=> st.ctrl[sadc_done_bit])
		else $error("done flag lost without clear");

	a_reserved_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		1'b1 |-> !st.ctrl[6] && !st.ctrl[4])
		else $error("reserved control bit set");

	a_result_ro: assert property (
		@(posedge pclk) disable iff (!presetn)
		acc && pwrite && paddr == sadc_result_addr && !conv_end
		|=> $stable(st.result))
		else $error("result register written");

	a_read_data: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && paddr == sadc_result_addr
		|=> prdata == {24'h0, $past(st.result)})
		else $error("result read data wrong");

	a_idle_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		!(psel && !penable && !pwrite) |=> prdata == 32'h0)
		else $error("read data not zero when idle");

	a_no_error: assert property (
		@(posedge pclk) disable iff (!presetn)
		acc |-> pready && !pslverr)
		else $error("access not answered cleanly");

	a_off_quiet: assert property (
		@(posedge pclk) disable iff (!presetn)
		st.phase == sadc_off |=> $stable(dac_code))
		else $error("trial code moved while off");

	a_wait_free: assert property (
		@(posedge pclk) disable iff (!presetn)
		cpu_wait && st.phase != sadc_off && !wr_ctrl
		|=> st.div == 2'($past(st.div) + 2'h1))
		else $error("converter stalled in wait mode");

endmodule // sadc_sequencer

// File: verification/sadc_analog_model.sv
// Behavioural sample-and-hold and comparator facing the sequencer.
// Assumes the bench supplies the level of the currently selected channel.
module sadc_analog_model
	import sadc_pkg::*;
(
	input wire logic pclk,
	input wire logic sample_connect,
	input wire logic [7:0] dac_code,
	input wire logic [7:0] level,
	output logic comp_above,
	output logic at_upper_ref,
	output logic at_lower_ref
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] held = 8'h00;
	// The capacitor follows the pin only while connected.
	always_ff @(posedge pclk) begin
		if (sample_connect) begin
			held <= level;
		end
	end
	assign comp_above = held >= dac_code;
	assign at_upper_ref = held == sadc_full_scale;
	assign at_lower_ref = held == sadc_zero_scale;
endmodule // sadc_analog_model

// File: verification/tb_sar_adc_sequencer.sv
// Self-checking bench for the converter sequencer over APB.
// Assumes the analog model above and a zero wait state slave.
module tb_sar_adc_sequencer
	import sadc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic cpu_wait = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, comp_above, at_upper_ref, at_lower_ref;
	logic sample_connect, converter_on, irq;
	logic [3:0] channel_select;
	logic [7:0] dac_code;
	logic [7:0] vin [16];
	logic [31:0] exp_q [$];
	int n_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	always #10 pclk = ~pclk;
	sadc_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_wait(cpu_wait), .comp_above(comp_above),
		.at_upper_ref(at_upper_ref), .at_lower_ref(at_lower_ref),
		.channel_select(channel_select), .sample_connect(sample_connect),
		.dac_code(dac_code), .converter_on(converter_on), .irq(irq));
	sadc_analog_model model (.pclk(pclk), .sample_connect(sample_connect),
		.dac_code(dac_code), .level(vin[channel_select]),
		.comp_above(comp_above), .at_upper_ref(at_upper_ref),
		.at_lower_ref(at_lower_ref));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Read data is compared at the edge that completes each read.
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready) begin
			chk(prdata, exp_q.pop_front());
		end
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles > 20000) begin
			n_errors++;
			report_and_stop();
		end
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(53454));
		foreach (vin[i]) vin[i] = 8'($urandom_range(254, 1));
		vin[0] = 8'hff;
		vin[1] = 8'h00;
		waitc(3);
		presetn <= 1'b1;
		rd(sadc_result_addr, 32'h0);
		rd(sadc_ctrl_addr, 32'h0);
		apb(1'b1, sadc_result_addr, 32'h5a);
		rd(sadc_result_addr, 32'h0);
		for (int ch = 0; ch < 16; ch++) begin
			apb(1'b1, sadc_ctrl_addr, 32'(8'h20 | ch));
			waitc(1);
			chk(32'(channel_select), 32'(ch));
			chk(32'(sample_connect), 32'h1);
			waitc(48);
			rd(sadc_ctrl_addr, 32'(8'ha0 | ch));
			rd(sadc_result_addr, 32'(vin[ch]));
			rd(sadc_ctrl_addr, 32'(8'h20 | ch));
		end
		waitc(40);
		rd(sadc_result_addr, 32'(vin[15]));
		apb(1'b1, sadc_ctrl_addr, 32'h2f);
		waitc(25);
		apb(1'b1, sadc_ctrl_addr, 32'h2f);
		waitc(38);
		rd(sadc_ctrl_addr, 32'h2f);
		apb(1'b1, sadc_ctrl_addr, 32'h2f);
		waitc(45);
		rd(sadc_result_addr, 32'(vin[15]));
		rd(sadc_ctrl_addr, 32'haf);
		apb(1'b1, sadc_irq_mask_addr, 32'h1);
		cpu_wait <= 1'b1;
		waitc(50);
		chk(32'(irq), 32'h1);
		apb(1'b1, sadc_ctrl_addr, 32'h05);
		apb(1'b1, sadc_irq_status_addr, 32'h3);
		waitc(2);
		chk(32'(irq), 32'h0);
		waitc(120);
		rd(sadc_irq_status_addr, 32'h0);
		chk(32'(converter_on), 32'h0);
		chk(32'(sample_connect), 32'h0);
		chk(32'(pslverr), 32'h0);
		rd(12'h0fc, 32'h0);
		report_and_stop();
	end
endmodule // tb_sar_adc_sequencer
